// file: include/ept_pkg.sv
// Shared constants and types for the execution pipeline timing block
`default_nettype none
package ept_pkg;
  // ---------------------------------------------------------------
  // Branch prediction and fetch
  // ---------------------------------------------------------------
  localparam logic [1:0] MAX_UNRES = 2'h2; // Predictions held in flight
  localparam logic [2:0] TGT_CNT = 3'h2; // Targets from target cache hit
  localparam logic [2:0] RELOAD_CNT = 3'h4; // Correct-path plus three
  localparam logic [2:0] NO_LOAD = 3'h0; // Nothing loaded this cycle

  // ---------------------------------------------------------------
  // Execution unit timing
  // ---------------------------------------------------------------
  localparam logic [5:0] INT_LAT = 6'h01; // Single-cycle integer op
  localparam logic [5:0] FP_LAT_MIN = 6'h03; // Typical float op, short
  localparam logic [5:0] FP_LAT_MAX = 6'h04; // Typical float op, long
  localparam logic [5:0] FP_LONG_MIN = 6'h0B; // Divide/estimate, least
  localparam logic [5:0] FP_LONG_MAX = 6'h21; // Divide/estimate, most
  localparam int unsigned FP_DEPTH = 3; // Float ops in flight

  // ---------------------------------------------------------------
  // Misprediction recovery sequence
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    FL_IDLE = 3'h1,
    FL_REFETCH = 3'h2,
    FL_RELOAD = 3'h4
  } ept_flush_e;
endpackage : ept_pkg
`default_nettype wire

// file: src/ept_float_pipe.sv
// Pipelined float unit occupancy and completion tracker
`default_nettype none
module ept_float_pipe (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic i_valid, // Float op offered
  input wire logic i_block, // Divide, estimate or status op
  input wire logic [5:0] i_lat, // Requested latency in cycles
  input wire logic i_thru, // Set: two-cycle throughput
  output logic o_busy, // No float op taken this cycle
  output logic [1:0] o_done // Ops completing this cycle
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [ept_pkg::FP_DEPTH-1:0][5:0] cnt; // Per-slot countdown
    logic blk; // Blocking op in flight
    logic gap; // Throughput bubble
    logic busy;
    logic [1:0] done;
  } ept_fp_s;

  ept_fp_s s_r;
  ept_fp_s s_nxt;
  logic take; // Op accepted this cycle
  logic placed; // Slot already found
  logic free; // Some slot idle next cycle
  logic [5:0] lat; // Clamped latency

  // Countdown, slot allocation and blocking
  always_comb begin
    s_nxt = s_r;
    take = i_valid && !s_r.busy;
    placed = 1'b0;
    free = 1'b0;
    s_nxt.done = 2'h0;
    // Long ops are held to their documented window
    if (i_block) begin
      if (i_lat < ept_pkg::FP_LONG_MIN) lat = ept_pkg::FP_LONG_MIN;
      else if (i_lat > ept_pkg::FP_LONG_MAX) lat = ept_pkg::FP_LONG_MAX;
      else lat = i_lat;
    end else begin
      lat = (i_lat == ept_pkg::FP_LAT_MAX) ? ept_pkg::FP_LAT_MAX : ept_pkg::FP_LAT_MIN;
    end
    for (int i = 0; i < ept_pkg::FP_DEPTH; i++) begin
      if (s_r.cnt[i] != 6'h00) begin
        s_nxt.cnt[i] = s_r.cnt[i] - 6'h01;
        if (s_r.cnt[i] == 6'h01) s_nxt.done = s_nxt.done + 2'h1;
      end
    end
    // Up to three ops overlap, one per slot
    for (int i = 0; i < ept_pkg::FP_DEPTH; i++) begin
      if (take && !placed && s_nxt.cnt[i] == 6'h00) begin
        s_nxt.cnt[i] = lat;
        placed = 1'b1;
      end
    end
    s_nxt.gap = take && i_thru;
    if (take) s_nxt.blk = i_block;
    if (s_nxt.cnt == '0) s_nxt.blk = 1'b0;
    for (int i = 0; i < ept_pkg::FP_DEPTH; i++) begin
      if (s_nxt.cnt[i] == 6'h00) free = 1'b1;
    end
    // Blocking op holds off all further float dispatch
    s_nxt.busy = s_nxt.blk || s_nxt.gap || !free;
  end

  // State register
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) s_r <= '0;
    else s_r <= s_nxt;
  end

  assign o_busy = s_r.busy;
  assign o_done = s_r.done;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_fp_block;
    @(posedge i_clock) disable iff (!i_rst_b)
    take && i_block |=> o_busy [*8];
  endproperty
  a_fp_block: assert property (p_fp_block) else $error("float pipe not blocked");

  property p_fp_long;
    @(posedge i_clock) disable iff (!i_rst_b)
    take && i_block && s_r.cnt == '0 |-> ##[12:34] o_done != 2'h0; // Done flag lags the count by one
  endproperty
  a_fp_long: assert property (p_fp_long) else $error("long float op latency");

  c_fp_long: cover property (@(posedge i_clock) take && i_block ##12 o_done != 2'h0);
endmodule : ept_float_pipe
`default_nettype wire

// file: src/ept_exec_timing.sv
// Execution pipeline timing control: prediction, flush, unit issue
`default_nettype none
module ept_exec_timing (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic i_branch_history_enable, // Config bit: dynamic guess
  input wire logic i_br_valid, // Unresolved conditional branch
  input wire logic i_br_hint, // Taken hint of options field
  input wire logic i_br_dyn, // Guess from history table
  input wire logic i_br_tgt_hit, // Target found in target cache
  input wire logic i_br_resolve, // Oldest branch condition known
  input wire logic i_br_taken, // Actual direction of oldest
  input wire logic i_int_valid, // Integer op offered
  input wire logic i_int_muldiv, // Op is multiply or divide
  input wire logic [5:0] i_int_cycles, // Execute cycles of the op
  input wire logic i_fp_valid, // Float op offered
  input wire logic i_fp_block, // Divide, estimate or status op
  input wire logic [5:0] i_fp_lat, // Float op latency
  input wire logic i_fp_thru, // Two-cycle throughput op
  input wire logic i_ls_valid, // Load or store offered
  input wire logic i_ls_load, // Set for a load
  input wire logic [2:0] i_ls_addr, // Low address bits
  input wire logic [1:0] i_ls_size, // 1, 2, 4 or 8 bytes
  input wire logic i_ls_multi, // Multiple or string op
  input wire logic i_ls_le, // Little-endian mode
  input wire logic i_ls_fp, // Float load or store
  input wire logic i_dc_miss, // Cache answer to current access
  input wire logic i_refill_done, // Missed line refilled
  output logic o_pred_valid, // Branch prediction made
  output logic o_pred_taken, // Direction of that prediction
  output logic o_fold, // Taken branch folded from queue
  output logic o_seq_flush, // Sequential fetch behind it dropped
  output logic [2:0] o_queue_load, // Instructions loaded into queue
  output logic o_fetch_stall, // Third branch refused
  output logic o_disp_hold, // Second path may not dispatch
  output logic o_wb_block, // Completion writeback blocked
  output logic o_flush, // Wrong path and renames flushed
  output logic o_refetch, // Refetch cycle
  output logic [1:0] o_unresolved, // Predictions in flight
  output logic [1:0] o_int_issue, // Unit taking an integer op
  output logic [1:0] o_int_busy, // Unit in multicycle op
  output logic [1:0] o_int_done, // Unit finishing an op
  output logic o_fp_busy, // Float op not taken
  output logic [1:0] o_fp_done, // Float ops finishing
  output logic o_ls_ready, // Load/store op may be offered
  output logic o_ls_dc_access, // Cache access this cycle
  output logic o_ls_done, // Load/store completes
  output logic o_ls_split, // Extra address calculation
  output logic o_align_exc, // Alignment exception taken
  output logic o_ls_miss_stall // Waiting for line refill
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    ept_pkg::ept_flush_e fl; // Recovery sequence
    logic [1:0] unres; // Unresolved predictions
    logic [1:0] pred; // Guessed directions, bit 0 oldest
    logic tgt; // Target delivery next cycle
    logic pv, pt, fold, seqf, stall, hold, wbb, flush, refetch;
    logic [2:0] qload;
    logic [1:0][5:0] ic; // Integer unit countdowns
    logic [1:0] iiss, ibusy, idone;
    logic s1v, s1l, s1x; // Address stage
    logic s2v, s2l; // Cache stage
    logic miss; // Missed load waiting refill
    logic lrdy, dacc, ldone, lsplit, aexc;
  } ept_state_s;

  localparam ept_state_s ST_RST = '{fl: ept_pkg::FL_IDLE, lrdy: 1'b1, default: '0};

  ept_state_s s_r;
  ept_state_s s_nxt;
  logic guess; // Chosen direction
  logic mis; // Oldest guess wrong
  logic br_acc; // Branch prediction taken on
  logic [5:0] ilat; // Integer countdown start
  logic [1:0] iu; // Integer unit chosen
  logic [2:0] lmask; // Natural alignment mask
  logic nat; // Operand naturally aligned
  logic exc; // Alignment exception case
  logic split; // Extra address calculation case
  logic ltake; // Load/store accepted
  logic acc_now; // Cache stage accessing

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    // Hint decides unless the history table is enabled
    guess = i_branch_history_enable ? i_br_dyn : i_br_hint;
    mis = i_br_resolve && (s_r.unres != 2'h0) && (i_br_taken != s_r.pred[0]);
    // New prediction only when fewer than two wait
    br_acc = i_br_valid && (s_r.unres < ept_pkg::MAX_UNRES) && !mis && (s_r.fl == ept_pkg::FL_IDLE);
    s_nxt.pv = br_acc;
    s_nxt.pt = br_acc && guess;
    s_nxt.fold = br_acc && guess;
    s_nxt.seqf = br_acc && guess;
    s_nxt.tgt = br_acc && guess && i_br_tgt_hit;
    s_nxt.qload = s_r.tgt ? ept_pkg::TGT_CNT : ept_pkg::NO_LOAD;
    s_nxt.stall = i_br_valid && !br_acc && (s_r.unres == ept_pkg::MAX_UNRES);
    s_nxt.flush = mis;
    s_nxt.refetch = 1'b0;
    // Prediction queue: wrong guess empties it
    if (mis) begin
      s_nxt.unres = 2'h0;
      s_nxt.pred = 2'h0;
    end else begin
      // Folded branch stays open until its condition is known
      if (i_br_resolve && s_r.unres != 2'h0) begin
        s_nxt.pred = {1'b0, s_r.pred[1]};
        s_nxt.unres = s_r.unres - 2'h1;
      end
      if (br_acc) begin
        s_nxt.pred[s_nxt.unres[0]] = guess;
        s_nxt.unres = s_nxt.unres + 2'h1;
      end
    end
    s_nxt.hold = (s_nxt.unres == ept_pkg::MAX_UNRES);
    // Results behind a guess may not retire; flush cycle too
    s_nxt.wbb = mis || (s_nxt.unres != 2'h0);
    // Recovery: flush, one refetch cycle, then reload
    case (s_r.fl)
      ept_pkg::FL_IDLE: begin
        if (mis) s_nxt.fl = ept_pkg::FL_REFETCH;
      end
      ept_pkg::FL_REFETCH: begin
        s_nxt.refetch = 1'b1;
        s_nxt.fl = ept_pkg::FL_RELOAD;
      end
      ept_pkg::FL_RELOAD: begin
        s_nxt.qload = ept_pkg::RELOAD_CNT;
        s_nxt.fl = ept_pkg::FL_IDLE;
      end
      default: begin
        s_nxt.fl = ept_pkg::FL_IDLE;
      end
    endcase

    // Integer units: countdown per unit
    ilat = (i_int_cycles < ept_pkg::INT_LAT) ? ept_pkg::INT_LAT : i_int_cycles;
    s_nxt.idone = 2'h0;
    for (int u = 0; u < 2; u++) begin
      if (s_r.ic[u] != 6'h00) begin
        s_nxt.ic[u] = s_r.ic[u] - 6'h01;
        s_nxt.idone[u] = (s_r.ic[u] == 6'h01);
      end
    end
    // Simple ops prefer unit two, keeping unit one for mul/div
    iu = 2'b00;
    if (i_int_valid) begin
      if (i_int_muldiv) iu = s_r.ibusy[0] ? 2'b00 : 2'b01;
      else if (!s_r.ibusy[1]) iu = 2'b10;
      else if (!s_r.ibusy[0]) iu = 2'b01;
    end
    s_nxt.iiss = iu;
    for (int u = 0; u < 2; u++) begin
      if (iu[u]) s_nxt.ic[u] = ilat;
      // A multicycle op closes its unit to new work
      s_nxt.ibusy[u] = s_nxt.ic[u] > ept_pkg::INT_LAT;
    end

    // Load/store: alignment classification
    case (i_ls_size)
      2'h0: lmask = 3'h0;
      2'h1: lmask = 3'h1;
      2'h2: lmask = 3'h3;
      default: lmask = 3'h7;
    endcase
    nat = (i_ls_addr & lmask) == 3'h0;
    if (i_ls_multi) exc = i_ls_le || (i_ls_addr[1:0] != 2'h0);
    else exc = i_ls_fp && (i_ls_addr[1:0] != 2'h0);
    split = !exc && (i_ls_multi || !nat);
    ltake = i_ls_valid && s_r.lrdy;
    s_nxt.aexc = ltake && exc;
    s_nxt.lsplit = 1'b0;
    s_nxt.ldone = 1'b0;
    acc_now = s_r.s2v && !s_r.miss;
    // Refill ends the wait and completes the missed load
    if (s_r.miss && i_refill_done) begin
      s_nxt.miss = 1'b0;
      s_nxt.ldone = 1'b1;
    end
    // Cache stage: a missing load parks, freeing the stage
    if (acc_now) begin
      if (s_r.s2l && i_dc_miss) s_nxt.miss = 1'b1;
      else s_nxt.ldone = 1'b1;
      s_nxt.s2v = 1'b0;
    end
    // Address stage: extra calculation, then move on
    if (s_r.s1v) begin
      if (s_r.s1x) begin
        s_nxt.s1x = 1'b0;
        s_nxt.lsplit = 1'b1;
      end else if (!s_nxt.s2v) begin
        s_nxt.s2v = 1'b1;
        s_nxt.s2l = s_r.s1l;
        s_nxt.s1v = 1'b0;
      end
    end
    if (ltake && !exc) begin
      s_nxt.s1v = 1'b1;
      s_nxt.s1l = i_ls_load;
      s_nxt.s1x = split;
    end
    // Refuse only when the address stage could not drain
    s_nxt.lrdy = !(s_nxt.miss && s_nxt.s1v) && !s_nxt.s1x;
    s_nxt.dacc = s_nxt.s2v && !s_nxt.miss;
  end

  // State register
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) s_r <= ST_RST;
    else s_r <= s_nxt;
  end

  // ---------------------------------------------------------------
  // Float unit
  // ---------------------------------------------------------------
  ept_float_pipe u_float (
    .i_clock(i_clock),
    .i_rst_b(i_rst_b),
    .i_valid(i_fp_valid),
    .i_block(i_fp_block),
    .i_lat(i_fp_lat),
    .i_thru(i_fp_thru),
    .o_busy(o_fp_busy),
    .o_done(o_fp_done)
  );

  // Outputs straight from the state register
  assign o_pred_valid = s_r.pv;
  assign o_pred_taken = s_r.pt;
  assign o_fold = s_r.fold;
  assign o_seq_flush = s_r.seqf;
  assign o_queue_load = s_r.qload;
  assign o_fetch_stall = s_r.stall;
  assign o_disp_hold = s_r.hold;
  assign o_wb_block = s_r.wbb;
  assign o_flush = s_r.flush;
  assign o_refetch = s_r.refetch;
  assign o_unresolved = s_r.unres;
  assign o_int_issue = s_r.iiss;
  assign o_int_busy = s_r.ibusy;
  assign o_int_done = s_r.idone;
  assign o_ls_ready = s_r.lrdy;
  assign o_ls_dc_access = s_r.dacc;
  assign o_ls_done = s_r.ldone;
  assign o_ls_split = s_r.lsplit;
  assign o_align_exc = s_r.aexc;
  assign o_ls_miss_stall = s_r.miss;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);

  property p_spec;
    br_acc |=> o_pred_valid && o_pred_taken == $past(guess);
  endproperty
  a_spec: assert property (p_spec) else $error("prediction not issued");

  property p_static;
    br_acc && !i_branch_history_enable |=> o_pred_taken == $past(i_br_hint);
  endproperty
  a_static: assert property (p_static) else $error("hint not used");

  property p_recover;
    mis |=> o_flush && o_wb_block ##1 o_refetch && !o_flush ##1 o_queue_load == ept_pkg::RELOAD_CNT;
  endproperty
  a_recover: assert property (p_recover) else $error("bad recovery sequence");

  property p_fold;
    br_acc && guess |=> o_fold && o_seq_flush && o_unresolved != 2'h0;
  endproperty
  a_fold: assert property (p_fold) else $error("taken guess not folded");

  property p_tgt;
    br_acc && guess && i_br_tgt_hit |-> ##2 o_queue_load == ept_pkg::TGT_CNT;
  endproperty
  a_tgt: assert property (p_tgt) else $error("targets not delivered");

  property p_third;
    i_br_valid && o_unresolved == 2'h2 && !i_br_resolve |=> o_fetch_stall && o_disp_hold;
  endproperty
  a_third: assert property (p_third) else $error("third branch not stalled");

  property p_muldiv;
    i_int_valid && i_int_muldiv |=> !o_int_issue[1];
  endproperty
  a_muldiv: assert property (p_muldiv) else $error("mul/div on unit two");

  property p_int1;
    i_int_valid && !i_int_muldiv && !o_int_busy[1] && i_int_cycles <= 6'h01 |=> o_int_issue[1] ##1 o_int_done[1];
  endproperty
  a_int1: assert property (p_int1) else $error("integer latency not one");

  property p_multi;
    o_int_busy[0] |=> !o_int_issue[0];
  endproperty
  a_multi: assert property (p_multi) else $error("busy unit took op");

  property p_ls2;
    ltake && !exc && !split && !s_r.s1v && !s_r.s2v && !s_r.miss |=> ##1 o_ls_dc_access ##1 ($past(i_dc_miss) || o_ls_done);
  endproperty
  a_ls2: assert property (p_ls2) else $error("load/store latency not two");

  property p_miss;
    s_r.miss && !i_refill_done |=> !o_ls_dc_access;
  endproperty
  a_miss: assert property (p_miss) else $error("access during refill");

  property p_lemulti;
    ltake && i_ls_multi && i_ls_le |=> o_align_exc && !o_ls_split;
  endproperty
  a_lemulti: assert property (p_lemulti) else $error("no alignment exception");

  property p_split;
    ltake && split |=> ##1 o_ls_split;
  endproperty
  a_split: assert property (p_split) else $error("split access missing");

  c_mis: cover property (mis ##3 o_queue_load == ept_pkg::RELOAD_CNT);
  c_tgt: cover property (br_acc && guess && i_br_tgt_hit);
  c_third: cover property (o_fetch_stall);
  c_refill: cover property (s_r.miss ##1 o_ls_done);
endmodule : ept_exec_timing
`default_nettype wire

// file: tb/ept_cache_model.sv
// Data cache partner model: lookup answers and line refill
`default_nettype none
module ept_cache_model #(parameter int REFILL = 5) (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic i_access, // Core looks up the cache
  input wire logic i_stall, // Core waits for a refill
  input wire logic i_want_miss, // Bench commands a miss
  output logic o_dc_miss, // Lookup answer
  output logic o_refill_done // Refill finished, one cycle
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last_r; // Last answer shown
  int cnt_r; // Refill cycles so far
  // Answer only in a lookup cycle; otherwise a changing value, never a stale one
  assign o_dc_miss = i_access ? i_want_miss : ~last_r;
  // ---------------------------------------------------------------
  // Refill timer, runs only while the core is stalled
  // ---------------------------------------------------------------
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      last_r <= 1'h0;
      cnt_r <= 0;
      o_refill_done <= 1'h0;
    end else begin
      last_r <= o_dc_miss;
      o_refill_done <= i_stall && (cnt_r == REFILL - 1);
      cnt_r <= i_stall ? cnt_r + 1 : 0;
    end
  end
endmodule : ept_cache_model
`default_nettype wire

// file: tb/tb_top.sv
// Self-checking bench for the execution pipeline timing block
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clock, i_rst_b, i_branch_history_enable, i_br_valid, i_br_hint, i_br_dyn, i_br_tgt_hit;
  logic i_br_resolve, i_br_taken, i_int_valid, i_int_muldiv, i_fp_valid, i_fp_block, i_fp_thru;
  logic i_ls_valid, i_ls_load, i_ls_multi, i_ls_le, i_ls_fp, i_dc_miss, i_refill_done, want_miss;
  logic [5:0] i_int_cycles, i_fp_lat;
  logic [2:0] i_ls_addr, o_queue_load;
  logic [1:0] i_ls_size, o_unresolved, o_int_issue, o_int_busy, o_int_done, o_fp_done;
  logic o_pred_valid, o_pred_taken, o_fold, o_seq_flush, o_fetch_stall, o_disp_hold, o_wb_block;
  logic o_flush, o_refetch, o_fp_busy, o_ls_ready, o_ls_dc_access, o_ls_done, o_ls_split;
  logic o_align_exc, o_ls_miss_stall;
  int mismatches = 0; // Failed comparisons
  int checks = 0; // All comparisons
  int cycles = 0; // Clock edges since start
  // ---------------------------------------------------------------
  // Block under test and its cache partner
  // ---------------------------------------------------------------
  ept_exec_timing DUT (.i_clock, .i_rst_b, .i_branch_history_enable, .i_br_valid, .i_br_hint,
    .i_br_dyn, .i_br_tgt_hit, .i_br_resolve, .i_br_taken, .i_int_valid, .i_int_muldiv, .i_int_cycles,
    .i_fp_valid, .i_fp_block, .i_fp_lat, .i_fp_thru, .i_ls_valid, .i_ls_load, .i_ls_addr, .i_ls_size,
    .i_ls_multi, .i_ls_le, .i_ls_fp, .i_dc_miss, .i_refill_done, .o_pred_valid, .o_pred_taken,
    .o_fold, .o_seq_flush, .o_queue_load, .o_fetch_stall, .o_disp_hold, .o_wb_block, .o_flush,
    .o_refetch, .o_unresolved, .o_int_issue, .o_int_busy, .o_int_done, .o_fp_busy, .o_fp_done,
    .o_ls_ready, .o_ls_dc_access, .o_ls_done, .o_ls_split, .o_align_exc, .o_ls_miss_stall);
  ept_cache_model cache (.i_clock, .i_rst_b, .i_access(o_ls_dc_access), .i_stall(o_ls_miss_stall),
    .i_want_miss(want_miss), .o_dc_miss(i_dc_miss), .o_refill_done(i_refill_done));
  // Free-running clock, 25 ns period
  initial begin
    i_clock = 1'h0;
    forever #12.5 i_clock = ~i_clock;
  end
  // Hang guard: far above the roughly 150 edges the tests need
  always @(posedge i_clock) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      mismatches++;
      close_out();
    end
  end
  // ---------------------------------------------------------------
  // Shared helpers
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [5:0] exp, input logic [5:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %0h seen %0h", nm, exp, got);
    end
  endtask : chk
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : close_out
  // Integer units: steering, single cycle, multicycle occupancy
  task automatic t_int;
    @(posedge i_clock);
    i_int_valid <= 1'h1;
    @(posedge i_clock);
    i_int_muldiv <= 1'h1; // Back to back: multiply follows
    i_int_cycles <= 6'h03;
    @(negedge i_clock);
    chk("int_issue", 6'h02, o_int_issue);
    @(posedge i_clock);
    i_int_valid <= 1'h0;
    @(negedge i_clock);
    chk("int_done", 6'h02, o_int_done);
    chk("int_issue_mul", 6'h01, o_int_issue);
    chk("int_busy", 6'h01, o_int_busy);
    repeat (3) @(posedge i_clock);
    @(negedge i_clock);
    chk("int_done_mul", 6'h01, o_int_done);
    $display("test integer finished");
  endtask : t_int
  // One float op; measures cycles to completion
  task automatic fp_lat(input logic b, t, input logic [5:0] l, input logic [5:0] exp);
    int n;
    repeat (2) @(posedge i_clock);
    i_fp_valid <= 1'h1;
    i_fp_block <= b;
    i_fp_thru <= t;
    i_fp_lat <= l;
    @(posedge i_clock);
    i_fp_valid <= 1'h0;
    @(negedge i_clock);
    chk("fp_busy", {5'h00, b | t}, {5'h00, o_fp_busy});
    // Counted from the issue cycle, as for the integer units
    n = 0;
    while (o_fp_done === 2'h0 && n < 40) begin
      @(negedge i_clock);
      n++;
    end
    chk("fp_lat", exp, n[5:0]);
  endtask : fp_lat
  // Float pipe: three in flight, then timing of a two-cycle throughput op and two long ops
  task automatic t_fp;
    @(posedge i_clock);
    i_fp_valid <= 1'h1;
    i_fp_lat <= 6'h03;
    repeat (3) @(posedge i_clock);
    i_fp_valid <= 1'h0;
    // First op finishes three cycles after its issue cycle
    @(posedge i_clock);
    repeat (3) begin
      @(negedge i_clock);
      chk("fp_done", 6'h01, {4'h0, o_fp_done});
    end
    fp_lat(1'h0, 1'h1, 6'h04, 6'h04);
    fp_lat(1'h1, 1'h0, 6'h0B, 6'h0B);
    fp_lat(1'h1, 1'h0, 6'h21, 6'h21);
    $display("test float finished");
  endtask : t_fp
  // One load/store; cycles to completion or exception
  task automatic ls_op(input logic [2:0] a, input logic m, le, ld, fp, input logic [5:0] exp, input logic ex);
    int n;
    int sp;
    repeat (2) @(posedge i_clock);
    i_ls_valid <= 1'h1;
    i_ls_addr <= a;
    i_ls_multi <= m;
    i_ls_le <= le;
    i_ls_load <= ld;
    i_ls_fp <= fp;
    @(posedge i_clock);
    i_ls_valid <= 1'h0;
    @(negedge i_clock);
    n = 1;
    sp = 0;
    while (o_ls_done !== 1'h1 && o_align_exc !== 1'h1 && n < 40) begin
      @(negedge i_clock);
      n++;
      sp += int'(o_ls_split === 1'h1);
    end
    chk("ls_lat", exp, n[5:0]);
    // Only the split cases pay one extra address cycle
    chk("ls_split", {5'h00, exp == 6'h04}, sp[5:0]);
    chk("ls_exc", {5'h00, ex}, {5'h00, o_align_exc});
  endtask : ls_op
  // Alignment costs: word loads, stores, multiples
  task automatic t_ls;
    ls_op(3'h0, 1'h0, 1'h0, 1'h1, 1'h0, 6'h03, 1'h0);
    ls_op(3'h0, 1'h0, 1'h1, 1'h0, 1'h0, 6'h03, 1'h0);
    ls_op(3'h1, 1'h0, 1'h0, 1'h1, 1'h0, 6'h04, 1'h0);
    ls_op(3'h1, 1'h0, 1'h1, 1'h1, 1'h0, 6'h04, 1'h0);
    ls_op(3'h0, 1'h1, 1'h0, 1'h1, 1'h0, 6'h04, 1'h0);
    ls_op(3'h0, 1'h1, 1'h1, 1'h1, 1'h0, 6'h01, 1'h1);
    ls_op(3'h1, 1'h0, 1'h0, 1'h1, 1'h1, 6'h01, 1'h1);
    $display("test load store finished");
  endtask : t_ls
  // Load miss with a hit queued behind it
  task automatic t_miss;
    int dn, bad;
    dn = 0;
    bad = 0;
    @(posedge i_clock);
    i_ls_valid <= 1'h1;
    i_ls_multi <= 1'h0;
    i_ls_le <= 1'h0;
    i_ls_load <= 1'h1;
    i_ls_fp <= 1'h0;
    i_ls_addr <= 3'h0;
    want_miss <= 1'h1;
    repeat (2) @(posedge i_clock);
    i_ls_valid <= 1'h0;
    @(posedge i_clock);
    want_miss <= 1'h0;
    @(negedge i_clock);
    chk("ls_stall", 6'h01, {5'h00, o_ls_miss_stall});
    repeat (20) begin
      @(negedge i_clock);
      dn += int'(o_ls_done === 1'h1);
      bad += int'(o_ls_miss_stall === 1'h1 && o_ls_dc_access === 1'h1);
    end
    chk("ls_dones", 6'h02, dn[5:0]);
    chk("ls_access_in_stall", 6'h00, bad[5:0]);
    $display("test load miss finished");
  endtask : t_miss
  // Two predictions, third refused, mispredict recovery, then history guess
  task automatic t_br;
    @(posedge i_clock);
    i_br_valid <= 1'h1;
    i_br_hint <= 1'h1;
    i_br_tgt_hit <= 1'h1;
    @(posedge i_clock);
    @(negedge i_clock);
    chk("pred", 6'h03, {4'h0, o_pred_valid, o_pred_taken});
    chk("fold", 6'h03, {4'h0, o_fold, o_seq_flush});
    @(negedge i_clock);
    chk("queue_tgt", 6'h02, {3'h0, o_queue_load});
    chk("open", 6'h02, {4'h0, o_unresolved});
    chk("hold_wb", 6'h03, {4'h0, o_disp_hold, o_wb_block});
    @(posedge i_clock);
    i_br_valid <= 1'h0;
    i_br_resolve <= 1'h1; // Guess was taken: wrong
    i_br_taken <= 1'h0;
    @(negedge i_clock);
    chk("fetch_stall", 6'h01, {5'h00, o_fetch_stall});
    @(posedge i_clock);
    i_br_resolve <= 1'h0;
    @(negedge i_clock);
    chk("flush", 6'h03, {4'h0, o_flush, o_wb_block});
    chk("open_after", 6'h00, {4'h0, o_unresolved});
    @(negedge i_clock);
    chk("refetch", 6'h02, {4'h0, o_refetch, o_wb_block});
    @(negedge i_clock);
    chk("queue_reload", 6'h04, {3'h0, o_queue_load});
    @(posedge i_clock);
    i_branch_history_enable <= 1'h1; // History says not taken
    i_br_valid <= 1'h1;
    @(posedge i_clock);
    i_br_valid <= 1'h0;
    i_br_resolve <= 1'h1;
    @(negedge i_clock);
    chk("pred_dyn", 6'h02, {4'h0, o_pred_valid, o_pred_taken});
    @(posedge i_clock);
    i_br_resolve <= 1'h0;
    @(negedge i_clock);
    chk("good_guess", 6'h00, {3'h0, o_flush, o_unresolved});
    $display("test branch finished");
  endtask : t_br
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    {i_rst_b, i_branch_history_enable, i_br_valid, i_br_hint, i_br_dyn, i_br_tgt_hit} = 6'h00;
    {i_br_resolve, i_br_taken, i_int_valid, i_int_muldiv, i_fp_valid, i_fp_block, i_fp_thru} = 7'h00;
    {i_ls_valid, i_ls_multi, i_ls_le, i_ls_fp, want_miss, i_ls_addr} = 8'h00;
    i_ls_load = 1'h1;
    i_ls_size = 2'h2;
    i_int_cycles = 6'h01;
    i_fp_lat = 6'h03;
    repeat (10) @(posedge i_clock);
    i_rst_b <= 1'h1;
    @(negedge i_clock);
    chk("reset_ready", 6'h01, {5'h00, o_ls_ready});
    chk("reset_open", 6'h00, {4'h0, o_unresolved});
    t_int();
    t_fp();
    t_ls();
    t_miss();
    t_br();
    close_out();
  end
endmodule : tb_top
`default_nettype wire
